// ==== logic/isw_pkg.sv ====
// Purpose: constants and carrier types for the indirect sram window
// Assumes: byte-wide host i/o cycles, one clock domain
// Notes: offsets are byte offsets from the window base
package isw_pkg;
    localparam logic [15:0] ISW_BASE_ADDR = 16'h0220;
    localparam logic [2:0] OFS_HIGH_ADDR = 3'h0;
    localparam logic [2:0] OFS_MID_ADDR = 3'h1;
    localparam logic [2:0] OFS_DATA_INC = 3'h2;
    localparam logic [2:0] OFS_DATA_FIX = 3'h3;
    localparam logic [2:0] OFS_WR_ENABLE = 3'h4;
    localparam int REG_COUNT = 5;
    localparam int WE_BIT = 0;
    localparam logic [7:0] LOW_COUNT_RESET = 8'h00;
    localparam logic [7:0] ADDR_BYTE_RESET = 8'h00;
    localparam logic WR_ENABLE_RESET = 1'b0;
    localparam logic [7:0] READ_IDLE = 8'h00;
    localparam int ARRAY_BYTES = 1048576;
    localparam int ARRAY_AW = 20;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } isw_req_s;

    typedef struct packed {
        logic [7:0] rdata;
        logic valid;
    } isw_rsp_s;
endpackage

// ==== logic/isw_window.sv ====
// Purpose: indirect byte window onto a battery-backed 1 MB static array
// Assumes: host strobes are one-cycle pulses synchronous to sys_clk
// Notes: read data appears one cycle after the read strobe
// Notes on behaviour
// - five byte registers decoded at consecutive offsets from a fixed base
// - one megabyte byte-wide array, data bits 7..0 on each data port
// - offset zero write latches address bits 23..16; write-only
// - offset one write latches address bits 15..8; write-only
// - writing the middle address also clears the low-byte counter
// - incrementing port write stores byte at high, middle, counter address
// - incrementing port read returns byte at high, middle, counter address
// - counter adds one after every incrementing port access
// - counter wraps in eight bits, no carry; software rewrites every 256 bytes
// - fixed port at offset three uses same address, counter unchanged
// - offset four bit 0: zero protects array, one makes it writeable
// - write enable cleared at power-up; software writes one before writing
`timescale 1ns/1ps
`default_nettype none
module isw_window
    import isw_pkg::*;
#(
    parameter logic [15:0] BASE_ADDR = ISW_BASE_ADDR,
    parameter int AW = ARRAY_AW
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // host i/o port
    input wire isw_req_s hostReq,
    output isw_rsp_s hostRsp,
    // status
    output logic wrEnable,
    output logic [23:0] accessAddr
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_READ = 2'b10
    } isw_state_e;

    // array is not reset: its content is kept by battery across power cycles
    logic [7:0] memArray [0:(1 << AW) - 1];

    logic [7:0] highAddr_reg, highAddr_next;
    logic [7:0] midAddr_reg, midAddr_next;
    logic [7:0] lowCount_reg, lowCount_next;
    logic wrEn_reg, wrEn_next;
    logic [7:0] rdData_reg, rdData_next;
    logic rdValid_reg, rdValid_next;
    isw_state_e state_reg, state_next;

    logic hit;
    logic [2:0] ofs;
    logic [15:0] delta;
    logic wrHigh, wrMid, wrInc, wrFix, wrCtl, rdInc, rdFix;
    logic memWrite;
    logic [AW-1:0] memIndex;

    always_comb begin
        delta = hostReq.addr - BASE_ADDR;
        hit = (delta < 16'(REG_COUNT));
        ofs = delta[2:0];
    end

    assign wrHigh = hit && hostReq.wr && (ofs == OFS_HIGH_ADDR);
    assign wrMid = hit && hostReq.wr && (ofs == OFS_MID_ADDR);
    assign wrInc = hit && hostReq.wr && (ofs == OFS_DATA_INC);
    assign wrFix = hit && hostReq.wr && (ofs == OFS_DATA_FIX);
    assign wrCtl = hit && hostReq.wr && (ofs == OFS_WR_ENABLE);
    assign rdInc = hit && hostReq.rd && (ofs == OFS_DATA_INC);
    assign rdFix = hit && hostReq.rd && (ofs == OFS_DATA_FIX);

    // upper address bits beyond the array size are latched but do not decode
    assign memIndex = AW'({highAddr_reg, midAddr_reg, lowCount_reg});
    assign memWrite = (wrInc || wrFix) && wrEn_reg;

    always_comb begin
        highAddr_next = highAddr_reg;
        midAddr_next = midAddr_reg;
        lowCount_next = lowCount_reg;
        wrEn_next = wrEn_reg;
        state_next = ST_IDLE;
        rdData_next = rdData_reg;
        rdValid_next = 1'b0;
        if (wrHigh) begin
            highAddr_next = hostReq.wdata;
        end
        if (wrMid) begin
            midAddr_next = hostReq.wdata;
            lowCount_next = LOW_COUNT_RESET;
        end
        // wraps in eight bits, never carries upward
        if (wrInc || rdInc) begin
            lowCount_next = lowCount_reg + 8'h01;
        end
        if (wrCtl) begin
            wrEn_next = hostReq.wdata[WE_BIT];
        end
        case (state_reg)
            ST_IDLE: begin
                if (rdInc || rdFix) begin
                    rdData_next = memArray[memIndex];
                    rdValid_next = 1'b1;
                    state_next = ST_READ;
                end
            end
            ST_READ: begin
                state_next = ST_IDLE;
                if (rdInc || rdFix) begin
                    rdData_next = memArray[memIndex];
                    rdValid_next = 1'b1;
                    state_next = ST_READ;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            highAddr_reg <= ADDR_BYTE_RESET;
            midAddr_reg <= ADDR_BYTE_RESET;
            lowCount_reg <= LOW_COUNT_RESET;
            wrEn_reg <= WR_ENABLE_RESET;
            rdData_reg <= READ_IDLE;
            rdValid_reg <= 1'b0;
            state_reg <= ST_IDLE;
        end else begin
            highAddr_reg <= highAddr_next;
            midAddr_reg <= midAddr_next;
            lowCount_reg <= lowCount_next;
            wrEn_reg <= wrEn_next;
            rdData_reg <= rdData_next;
            rdValid_reg <= rdValid_next;
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (memWrite) begin
            memArray[memIndex] <= hostReq.wdata;
        end
    end

    assign hostRsp.rdata = rdData_reg;
    assign hostRsp.valid = rdValid_reg;
    assign wrEnable = wrEn_reg;
    assign accessAddr = {highAddr_reg, midAddr_reg, lowCount_reg};
endmodule
`default_nettype wire

// ==== test/isw_window_properties.sv ====
// Purpose: port checks. Assumes: one clock. Notes: offsets from the base
`timescale 1ns/1ps
`default_nettype none
module isw_window_properties import isw_pkg::*; (
    input wire logic sys_clk, reset_n,
    input wire isw_req_s hostReq, input wire isw_rsp_s hostRsp,
    input wire logic wrEnable, input wire logic [23:0] accessAddr
);
    wire logic [15:0] o = hostReq.addr - ISW_BASE_ADDR;
    wire logic w = hostReq.wr, s = w | hostReq.rd;
    wire logic r = hostReq.rd && (o == 2 || o == 3);
    wire logic [7:0] d = hostReq.wdata;
    wire logic [23:0] a = accessAddr;
    wire logic [7:0] n = a[7:0] + 8'h01;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_hi_byte: assert property (w && o == 0 |=> a[23:16] == $past(d)) else $error("high");
    a_mid_byte: assert property (w && o == 1 |=> a[15:8] == $past(d)) else $error("mid");
    a_low_clear: assert property (w && o == 1 |=> a[7:0] == 8'h00) else $error("clr");
    a_inc_step: assert property (s && o == 2 |=> a[7:0] == $past(n)) else $error("inc");
    a_fix_hold: assert property (s && o == 3 |=> $stable(a)) else $error("fix");
    a_we_set: assert property (w && o == 4 |=> wrEnable == $past(d[0])) else $error("we");
    a_rd_valid: assert property (r |=> hostRsp.valid) else $error("valid");
    a_no_valid: assert property (!r |=> !hostRsp.valid) else $error("stray");
endmodule
bind isw_window isw_window_properties chk (.*);
`default_nettype wire

// ==== test/tb_isw_window.sv ====
// Purpose: window bench. Assumes: one clock. Notes: array seen via reads
`timescale 1ns/1ps
`default_nettype none
module tb_isw_window import isw_pkg::*; ;
    logic sys_clk = 1'b0, reset_n = 1'b0;
    isw_req_s hostReq = '0;
    isw_rsp_s hostRsp;
    logic wrEnable;
    logic [23:0] accessAddr;
    int err_total = 0, total_checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    isw_window uut (.*);
    task automatic chk(input logic [23:0] s, e);
        total_checks++;
        if (s !== e) err_total++;
        if (s !== e) $display("MISMATCH %0t %h vs %h", $time, s, e);
    endtask
    task automatic acc(input logic [2:0] o, logic [7:0] d, logic w);
        @(posedge sys_clk) #1;
        hostReq = '{ISW_BASE_ADDR + 16'(o), d, w, !w};
        @(posedge sys_clk) #1;
        hostReq = '0;
        if (!w) chk({15'h0, hostRsp.valid, hostRsp.rdata}, {16'h1, d});
    endtask
    task automatic end_of_test();
        $display("%0d checks %0d bad", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #20000 err_total++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        chk({23'h0, wrEnable}, 24'h000000);
        acc(3'h0, 8'h05, 1'b1);
        acc(3'h4, 8'h01, 1'b1);
        chk({23'h0, wrEnable}, 24'h000001);
        acc(3'h1, 8'h12, 1'b1);
        acc(3'h2, 8'h3C, 1'b1);
        acc(3'h2, 8'h5A, 1'b1);
        acc(3'h1, 8'h34, 1'b1);
        for (int i = 0; i < 256; i++) acc(3'h2, 8'(i), 1'b1);
        acc(3'h2, 8'h00, 1'b0);
        $display("wrap done");
        acc(3'h4, 8'h00, 1'b1);
        chk({23'h0, wrEnable}, 24'h000000);
        acc(3'h1, 8'h12, 1'b1);
        acc(3'h2, 8'hFF, 1'b1);
        acc(3'h1, 8'h12, 1'b1);
        acc(3'h2, 8'h3C, 1'b0);
        acc(3'h3, 8'h5A, 1'b0);
        acc(3'h2, 8'h5A, 1'b0);
        acc(3'h5, 8'h99, 1'b1);
        chk(accessAddr, 24'h051202);
        $display("data done");
        end_of_test();
    end
endmodule
`default_nettype wire
